// ==== common/bst_pkg.sv ====
// boundary-scan tap package: instruction codes, chain sizes, tap states
// assumes a single system clock that oversamples the test clock pin
package bst_pkg;
    localparam int IR_W = 8;
    localparam int BSR_LEN = 391;
    localparam int ID_W = 32;
    localparam int SYNC_STAGES = 2;
    localparam int TMS_RESET_EDGES = 5;

    localparam logic [7:0] IR_EXTEST = 8'h00;
    localparam logic [7:0] IR_SAMPLE = 8'h01;
    localparam logic [7:0] IR_IDCODE = 8'h03;
    localparam logic [7:0] IR_HIGHZ = 8'h10;
    localparam logic [7:0] IR_BYPASS = 8'hFF;
    // instruction held after test-logic reset
    localparam logic [7:0] IR_RESET_VAL = IR_IDCODE;
    // fixed pattern captured into the instruction shifter
    localparam logic [7:0] IR_CAPTURE_VAL = 8'h01;
    localparam logic BYPASS_CAPTURE_VAL = 1'b0;

    localparam logic SYNC_TCK_RST = 1'b0;
    localparam logic SYNC_TMS_RST = 1'b1;
    localparam logic SYNC_TDI_RST = 1'b1;
    localparam logic SYNC_TRSTN_RST = 1'b1;
    localparam logic TDO_RESET_VAL = 1'b0;
    localparam logic TDO_OE_RESET_VAL = 1'b1;

    // gray-coded along the data and instruction paths
    typedef enum logic [3:0] {
        ST_RESET = 4'h0,
        ST_IDLE = 4'h1,
        ST_SEL_DR = 4'h3,
        ST_CAP_DR = 4'h2,
        ST_SH_DR = 4'h6,
        ST_EX1_DR = 4'h7,
        ST_PAU_DR = 4'h5,
        ST_EX2_DR = 4'h4,
        ST_UPD_DR = 4'hC,
        ST_SEL_IR = 4'hD,
        ST_CAP_IR = 4'hF,
        ST_SH_IR = 4'hE,
        ST_EX1_IR = 4'hA,
        ST_PAU_IR = 4'hB,
        ST_EX2_IR = 4'h9,
        ST_UPD_IR = 4'h8
    } bst_state_t;
endpackage : bst_pkg

// ==== common/bst_tap_if.sv ====
// signals between the scan datapath and its tap state machine
// assumes both ends run on the same system clock
`timescale 1ns/1ps
interface bst_tap_if;
    import bst_pkg::*;
    logic tckRise;
    logic tmsLvl;
    logic trstLvl;
    bst_state_t state;
    modport ctl (input tckRise, input tmsLvl, input trstLvl, output state);
    modport usr (output tckRise, output tmsLvl, output trstLvl, input state);
endinterface : bst_tap_if

// ==== hw/bst_tap_fsm.sv ====
// sixteen-state tap controller, stepped on detected test-clock rises
// assumes tms and test reset are already synchronised to clk
`timescale 1ns/1ps
module bst_tap_fsm
    import bst_pkg::*;
(
    // system
    input wire logic clk,
    input wire logic reset,
    // datapath side
    bst_tap_if.ctl tap
);
    bst_state_t state_ff;
    bst_state_t nxt_state;
    logic [2:0] tmsRun_ff;
    logic [2:0] nxt_tmsRun;
    localparam logic [2:0] TMS_SAT = 3'(TMS_RESET_EDGES);

    always_comb begin
        nxt_state = state_ff;
        if (tap.trstLvl) begin
            nxt_state = ST_RESET;
        end else if (tap.tckRise) begin
            unique case (state_ff)
                ST_RESET: nxt_state = tap.tmsLvl ? ST_RESET : ST_IDLE;
                ST_IDLE: nxt_state = tap.tmsLvl ? ST_SEL_DR : ST_IDLE;
                ST_SEL_DR: nxt_state = tap.tmsLvl ? ST_SEL_IR : ST_CAP_DR;
                ST_CAP_DR: nxt_state = tap.tmsLvl ? ST_EX1_DR : ST_SH_DR;
                ST_SH_DR: nxt_state = tap.tmsLvl ? ST_EX1_DR : ST_SH_DR;
                ST_EX1_DR: nxt_state = tap.tmsLvl ? ST_UPD_DR : ST_PAU_DR;
                ST_PAU_DR: nxt_state = tap.tmsLvl ? ST_EX2_DR : ST_PAU_DR;
                ST_EX2_DR: nxt_state = tap.tmsLvl ? ST_UPD_DR : ST_SH_DR;
                ST_UPD_DR: nxt_state = tap.tmsLvl ? ST_SEL_DR : ST_IDLE;
                ST_SEL_IR: nxt_state = tap.tmsLvl ? ST_RESET : ST_CAP_IR;
                ST_CAP_IR: nxt_state = tap.tmsLvl ? ST_EX1_IR : ST_SH_IR;
                ST_SH_IR: nxt_state = tap.tmsLvl ? ST_EX1_IR : ST_SH_IR;
                ST_EX1_IR: nxt_state = tap.tmsLvl ? ST_UPD_IR : ST_PAU_IR;
                ST_PAU_IR: nxt_state = tap.tmsLvl ? ST_EX2_IR : ST_PAU_IR;
                ST_EX2_IR: nxt_state = tap.tmsLvl ? ST_UPD_IR : ST_SH_IR;
                ST_UPD_IR: nxt_state = tap.tmsLvl ? ST_SEL_DR : ST_IDLE;
            endcase
        end
    end

    // the processor reset is deliberately not a term here
    always_ff @(posedge clk) begin
        state_ff <= nxt_state;
    end

    assign tap.state = state_ff;

    // helper: consecutive tms-high rises, saturating
    always_comb begin
        nxt_tmsRun = tmsRun_ff;
        if (tap.tckRise) begin
            nxt_tmsRun = !tap.tmsLvl ? 3'h0 : (tmsRun_ff == TMS_SAT) ? TMS_SAT : tmsRun_ff + 3'h1;
        end
    end

    always_ff @(posedge clk) begin
        tmsRun_ff <= reset ? 3'h0 : nxt_tmsRun;
    end

    a_trst_forces_reset: assert property (
        @(posedge clk) disable iff (reset) tap.trstLvl |=> state_ff == ST_RESET)
        else $error("test reset did not force the reset state");

    a_five_tms_reset: assert property (
        @(posedge clk) disable iff (reset) tmsRun_ff == TMS_SAT |-> state_ff == ST_RESET)
        else $error("five tms-high rises did not reach the reset state");
endmodule : bst_tap_fsm

// ==== hw/bst_tap.sv ====
// boundary-scan test access logic: instruction decode, data registers, pins
// assumes tck/tms/tdi/trstN come straight from pins and tck is far below clk
`timescale 1ns/1ps
module bst_tap
    import bst_pkg::*;
#(
    parameter int CHAIN_LEN = BSR_LEN,
    // arbitrary neutral identification value
    parameter logic [ID_W-1:0] ID_VALUE = 32'h0A5A_5001
) (
    // system
    input wire logic clk,
    input wire logic reset,
    // test port pins
    input wire logic tck,
    input wire logic tms,
    input wire logic tdi,
    input wire logic trstN,
    output logic tdo,
    output logic tdoOe,
    // core status
    input wire logic pcTraceOn,
    // boundary pins
    input wire logic [CHAIN_LEN-1:0] corePinOut,
    input wire logic [CHAIN_LEN-1:0] pinIn,
    output logic [CHAIN_LEN-1:0] pinOut,
    output logic pinHighZ,
    // core debug support unit
    output logic dbgSel,
    output logic [IR_W-1:0] dbgIr,
    output logic dbgCapture,
    output logic dbgShift,
    output logic dbgUpdate,
    output logic dbgTdi,
    input wire logic dbgTdo
);
    bst_tap_if tap ();

    logic [2:0] tck_ff, tms_ff, tdi_ff, trstN_ff;
    logic [2:0] nxt_tck, nxt_tms, nxt_tdi, nxt_trstN;
    logic tckRise, tckFall, tmsS, tdiS;

    // stage 0 is only read by stage 1; edges come from stages 1 and 2
    always_comb begin
        nxt_tck = {tck_ff[1:0], tck};
        nxt_tms = {tms_ff[1:0], tms};
        nxt_tdi = {tdi_ff[1:0], tdi};
        nxt_trstN = {trstN_ff[1:0], trstN};
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            tck_ff <= {3{SYNC_TCK_RST}};
            tms_ff <= {3{SYNC_TMS_RST}};
            tdi_ff <= {3{SYNC_TDI_RST}};
            trstN_ff <= {3{SYNC_TRSTN_RST}};
        end else begin
            tck_ff <= nxt_tck;
            tms_ff <= nxt_tms;
            tdi_ff <= nxt_tdi;
            trstN_ff <= nxt_trstN;
        end
    end

    // edges seen during processor reset are not counted
    assign tckRise = !reset && tck_ff[1] && !tck_ff[2];
    assign tckFall = !reset && !tck_ff[1] && tck_ff[2];
    assign tmsS = tms_ff[1];
    assign tdiS = tdi_ff[1];

    assign tap.tckRise = tckRise;
    assign tap.tmsLvl = tmsS;
    assign tap.trstLvl = !trstN_ff[1];

    bst_tap_fsm u_fsm (
        .clk(clk),
        .reset(reset),
        .tap(tap)
    );

    bst_state_t st;
    assign st = tap.state;

    // instruction decode
    logic [IR_W-1:0] ir_ff, nxt_ir, irSh_ff, nxt_irSh;
    logic selBsr, selId, selDbg, isExtest, isHighZ;

    always_comb begin
        isExtest = !pcTraceOn && ir_ff == IR_EXTEST;
        isHighZ = !pcTraceOn && ir_ff == IR_HIGHZ;
        selBsr = !pcTraceOn && (ir_ff == IR_EXTEST || ir_ff == IR_SAMPLE);
        selId = ir_ff == IR_IDCODE;
        selDbg = ir_ff[IR_W-1] && ir_ff != IR_BYPASS;
        // everything else, reserved codes included, falls to bypass
    end

    always_comb begin
        nxt_ir = ir_ff;
        nxt_irSh = irSh_ff;
        if (st == ST_RESET) begin
            nxt_ir = IR_RESET_VAL;
        end else if (tckRise) begin
            unique case (st)
                ST_CAP_IR: nxt_irSh = IR_CAPTURE_VAL;
                ST_SH_IR: nxt_irSh = {tdiS, irSh_ff[IR_W-1:1]};
                ST_UPD_IR: nxt_ir = irSh_ff;
                default: nxt_irSh = irSh_ff;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        ir_ff <= nxt_ir;
        irSh_ff <= nxt_irSh;
    end

    // data registers; cell k of the pin sequence is bit k, with bit 0 next out on tdo
    logic [CHAIN_LEN-1:0] bsr_ff, nxt_bsr, bsrUpd_ff, nxt_bsrUpd;
    logic [ID_W-1:0] id_ff, nxt_id;
    logic byp_ff, nxt_byp;

    always_comb begin
        nxt_bsr = bsr_ff;
        nxt_bsrUpd = bsrUpd_ff;
        nxt_id = id_ff;
        nxt_byp = byp_ff;
        if (tckRise && st == ST_CAP_DR) begin
            if (selBsr) begin
                nxt_bsr = pinIn;
            end
            nxt_id = ID_VALUE;
            nxt_byp = BYPASS_CAPTURE_VAL;
        end else if (tckRise && st == ST_SH_DR) begin
            if (selBsr) begin
                nxt_bsr = {tdiS, bsr_ff[CHAIN_LEN-1:1]};
            end
            if (selId) begin
                nxt_id = {tdiS, id_ff[ID_W-1:1]};
            end
            nxt_byp = tdiS;
        end else if (tckRise && st == ST_UPD_DR && selBsr) begin
            nxt_bsrUpd = bsr_ff;
        end
    end

    always_ff @(posedge clk) begin
        bsr_ff <= nxt_bsr;
        bsrUpd_ff <= nxt_bsrUpd;
        id_ff <= nxt_id;
        byp_ff <= nxt_byp;
    end

    // serial output changes on the falling test clock
    logic tdo_ff, nxt_tdo, tdoOe_ff, nxt_tdoOe, serialBit;

    always_comb begin
        if (st == ST_SH_IR) begin
            serialBit = irSh_ff[0];
        end else if (selBsr) begin
            serialBit = bsr_ff[0];
        end else if (selId) begin
            serialBit = id_ff[0];
        end else if (selDbg) begin
            serialBit = dbgTdo;
        end else begin
            serialBit = byp_ff;
        end
        nxt_tdo = tdo_ff;
        nxt_tdoOe = tdoOe_ff;
        if (tckFall) begin
            nxt_tdoOe = !(st == ST_SH_DR || st == ST_SH_IR);
            nxt_tdo = serialBit;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            tdo_ff <= TDO_RESET_VAL;
            tdoOe_ff <= TDO_OE_RESET_VAL;
        end else begin
            tdo_ff <= nxt_tdo;
            tdoOe_ff <= nxt_tdoOe;
        end
    end

    assign tdo = tdo_ff;
    assign tdoOe = tdoOe_ff;

    // pin side
    logic [CHAIN_LEN-1:0] pinOut_ff, nxt_pinOut;
    logic pinHighZ_ff, nxt_pinHighZ;

    always_comb begin
        nxt_pinOut = isExtest ? bsrUpd_ff : corePinOut;
        nxt_pinHighZ = isHighZ;
    end

    always_ff @(posedge clk) begin
        pinOut_ff <= nxt_pinOut;
        pinHighZ_ff <= nxt_pinHighZ;
    end

    assign pinOut = pinOut_ff;
    assign pinHighZ = pinHighZ_ff;

    // debug unit strobes are plain pulses with no acknowledge, one clk wide per tck rise
    assign dbgSel = selDbg;
    assign dbgIr = ir_ff;
    assign dbgCapture = selDbg && tckRise && st == ST_CAP_DR;
    assign dbgShift = selDbg && tckRise && st == ST_SH_DR;
    assign dbgUpdate = selDbg && tckRise && st == ST_UPD_DR;
    assign dbgTdi = tdiS;

    sequence s_shift_dr;
        tckRise && st == ST_SH_DR;
    endsequence

    a_ir_lsb_first: assert property (
        @(posedge clk) disable iff (reset)
        tckRise && st == ST_SH_IR |=> irSh_ff[IR_W-1] == $past(tdiS) &&
            irSh_ff[IR_W-2:0] == $past(irSh_ff[IR_W-1:1]))
        else $error("instruction shift direction wrong");

    a_bsr_msb_in: assert property (
        @(posedge clk) disable iff (reset)
        s_shift_dr ##0 selBsr |=> bsr_ff[CHAIN_LEN-1] == $past(tdiS) &&
            bsr_ff[0] == $past(bsr_ff[1]))
        else $error("boundary chain shift direction wrong");

    a_tdo_from_bsr: assert property (
        @(posedge clk) disable iff (reset)
        tckFall && st == ST_SH_DR && selBsr |=> tdo == $past(bsr_ff[0]) && !tdoOe)
        else $error("tdo not taken from boundary lsb");

    a_tdo_from_id: assert property (
        @(posedge clk) disable iff (reset)
        tckFall && st == ST_SH_DR && selId && !pcTraceOn |=> tdo == $past(id_ff[0]))
        else $error("tdo not taken from identification lsb");

    a_id_capture: assert property (
        @(posedge clk) disable iff (reset)
        tckRise && st == ST_CAP_DR |=> id_ff == ID_VALUE)
        else $error("identification value not captured");

    a_bypass_zero: assert property (
        @(posedge clk) disable iff (reset)
        tckRise && st == ST_CAP_DR |=> byp_ff == 1'b0)
        else $error("bypass cell did not capture zero");

    a_highz_pins: assert property (
        @(posedge clk) disable iff (reset)
        ir_ff == IR_HIGHZ && !pcTraceOn ##1 ir_ff == IR_HIGHZ && !$past(pcTraceOn) |-> pinHighZ)
        else $error("highz did not float outputs");

    a_trace_blocks: assert property (
        @(posedge clk) disable iff (reset)
        pcTraceOn |-> !selBsr ##1 (pinOut == $past(corePinOut)))
        else $error("boundary scan active while tracing");

    a_extest_drive: assert property (
        @(posedge clk) disable iff (reset)
        isExtest |=> pinOut == $past(bsrUpd_ff))
        else $error("extest did not drive update cells");

    a_dbg_select: assert property (
        @(posedge clk) disable iff (reset)
        ir_ff[IR_W-1] && ir_ff != IR_BYPASS |-> dbgSel ##0 !selBsr && !selId)
        else $error("debug code not passed to core debug unit");
endmodule : bst_tap

// ==== bench/bst_probe.sv ====
// scan controller model: steps the test port pins one tck period at a time
// assumes clk runs far above tck; pins change only just after a clk rise
`timescale 1ns/1ps
module bst_probe
    import bst_pkg::*;
(
    // system
    input wire logic clk,
    // test port
    output logic tck,
    output logic tms,
    output logic tdi,
    output logic trstN,
    input wire logic tdo,
    input wire logic tdoOe
);
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
        trstN = 1'b0;
    end

    // test reset pin pulse; clk keeps running meanwhile
    task testReset();
        trstN <= 1'b0;
        repeat (4) @(posedge clk);
        trstN <= 1'b1;
        repeat (4) @(posedge clk);
    endtask : testReset

    // one tck period of 8 clk; tdo settles 3 clk after the fall, taken before the rise
    task step(input logic m, input logic d, output logic o, output logic oe);
        tck <= 1'b0;
        tms <= m;
        tdi <= d;
        repeat (4) @(posedge clk);
        o = tdo;
        oe = tdoOe;
        tck <= 1'b1;
        repeat (4) @(posedge clk);
    endtask : step

    // tck left low so a processor reset cannot mistake a high pin for a rise
    task park();
        tck <= 1'b0;
        repeat (4) @(posedge clk);
    endtask : park

    // tms path given lsb first
    task walk(input logic [7:0] path, input int n);
        logic o, oe;
        for (int i = 0; i < n; i++) begin
            step(path[i], 1'b1, o, oe);
        end
    endtask : walk

    // only legal codes are ever handed in here
    task loadIr(input logic [IR_W-1:0] code, output logic [IR_W-1:0] cap);
        logic oe;
        walk(8'h03, 4);
        for (int i = 0; i < IR_W; i++) begin
            step(i == IR_W - 1, code[i], cap[i], oe);
        end
        walk(8'h01, 2);
    endtask : loadIr

    task scanDr(input int n, input logic [BSR_LEN-1:0] din,
                output logic [BSR_LEN-1:0] dout, output logic oeAny);
        logic oe;
        dout = '0;
        oeAny = 1'b0;
        walk(8'h01, 3);
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, din[i], dout[i], oe);
            oeAny = oeAny | oe;
        end
        walk(8'h01, 2);
    endtask : scanDr
endmodule : bst_probe

// ==== bench/bst_tap_tb.sv ====
// self-checking bench for the boundary-scan test access block
// assumes the probe model drives all test port pins
`timescale 1ns/1ps
module bst_tap_tb;
    import bst_pkg::*;
    // arbitrary identification value for this bench
    localparam logic [ID_W-1:0] ID_TB = 32'h1357_9BDF;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic tck, tms, tdi, trstN, tdo, tdoOe;
    logic pcTraceOn = 1'b0;
    logic dbgTdo = 1'b0;
    logic [BSR_LEN-1:0] corePinOut, pinIn, pinOut, pat, shin, d;
    logic pinHighZ, dbgSel, dbgCapture, dbgShift, dbgUpdate, dbgTdi, oe;
    logic [IR_W-1:0] dbgIr, cap;
    logic [IR_W-1:0] codes [2] = '{IR_BYPASS, IR_HIGHZ};
    int errCount = 0;
    int samplesChecked = 0;
    int cycles = 0;
    int capN = 0, shN = 0, shOnes = 0, updN = 0;

    always #10 clk = ~clk;

    // debug unit strobes counted as seen at each clk rise
    always @(posedge clk) begin
        capN += (dbgCapture === 1'b1);
        shN += (dbgShift === 1'b1);
        shOnes += (dbgShift === 1'b1 && dbgTdi === 1'b1);
        updN += (dbgUpdate === 1'b1);
    end

    bst_tap #(.CHAIN_LEN(BSR_LEN), .ID_VALUE(ID_TB)) i_bst_tap (.clk(clk), .reset(reset),
        .tck(tck), .tms(tms), .tdi(tdi), .trstN(trstN), .tdo(tdo), .tdoOe(tdoOe),
        .pcTraceOn(pcTraceOn), .corePinOut(corePinOut), .pinIn(pinIn), .pinOut(pinOut),
        .pinHighZ(pinHighZ), .dbgSel(dbgSel), .dbgIr(dbgIr), .dbgCapture(dbgCapture),
        .dbgShift(dbgShift), .dbgUpdate(dbgUpdate), .dbgTdi(dbgTdi), .dbgTdo(dbgTdo));
    bst_probe i_bst_probe (.clk(clk), .tck(tck), .tms(tms), .tdi(tdi), .trstN(trstN),
        .tdo(tdo), .tdoOe(tdoOe));

    task chk(input string what, input logic [BSR_LEN-1:0] seen, input logic [BSR_LEN-1:0] exp);
        samplesChecked++;
        if (seen !== exp) begin
            errCount++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task finishTest();
        $display("checks %0d mismatches %0d", samplesChecked, errCount);
        if (errCount == 0 && samplesChecked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : finishTest

    // hang guard well above the roughly 7.7k cycles the sequence needs
    always @(posedge clk) begin
        cycles++;
        if (cycles == 60000) begin
            errCount++;
            finishTest();
        end
    end

    task tIdcode();
        i_bst_probe.walk(8'h00, 1);
        chk("ir after reset", dbgIr, IR_IDCODE);
        i_bst_probe.scanDr(ID_W, '0, d, oe);
        chk("id word", d, ID_TB);
        chk("oe in shift", oe, 1'b0);
        chk("oe idle", tdoOe, 1'b1);
    endtask : tIdcode

    task tBypass();
        foreach (codes[k]) begin
            i_bst_probe.loadIr(codes[k], cap);
            // pin-side outputs settle one clk after the instruction changes
            @(posedge clk);
            chk("ir capture", cap, IR_CAPTURE_VAL);
            chk("active ir", dbgIr, codes[k]);
            chk("float", pinHighZ, codes[k] == IR_HIGHZ);
            i_bst_probe.scanDr(8, 8'hB4, d, oe);
            chk("bypass out", d, 8'h68);
        end
        @(posedge clk) pcTraceOn <= 1'b1;
        repeat (3) @(posedge clk);
        chk("float trace on", pinHighZ, 1'b0);
        pcTraceOn <= 1'b0;
    endtask : tBypass

    task tBoundary();
        i_bst_probe.loadIr(IR_SAMPLE, cap);
        i_bst_probe.scanDr(BSR_LEN, shin, d, oe);
        chk("sample capture", d, pat);
        chk("pins functional", pinOut, corePinOut);
        i_bst_probe.loadIr(IR_EXTEST, cap);
        @(posedge clk);
        chk("preloaded pins", pinOut, shin);
        i_bst_probe.scanDr(BSR_LEN, ~shin, d, oe);
        chk("extest capture", d, pat);
        @(posedge clk);
        chk("extest pins", pinOut, ~shin);
        @(posedge clk) pcTraceOn <= 1'b1;
        repeat (3) @(posedge clk);
        chk("trace pins", pinOut, corePinOut);
        pcTraceOn <= 1'b0;
    endtask : tBoundary

    task tDebug();
        i_bst_probe.loadIr(8'h80, cap);
        chk("debug select", dbgSel, 1'b1);
        chk("debug ir", dbgIr, 8'h80);
        @(posedge clk) dbgTdo <= 1'b1;
        i_bst_probe.scanDr(8, 8'h0F, d, oe);
        chk("debug tdo", d, 8'hFF);
        chk("debug captures", capN, 1);
        chk("debug shifts", shN, 8);
        chk("debug tdi ones", shOnes, 4);
        chk("debug updates", updN, 1);
        dbgTdo <= 1'b0;
    endtask : tDebug

    task tResets();
        i_bst_probe.loadIr(IR_BYPASS, cap);
        i_bst_probe.park();
        reset <= 1'b1;
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        repeat (4) @(posedge clk);
        chk("ir kept", dbgIr, IR_BYPASS);
        i_bst_probe.walk(8'h1F, 5);
        chk("ir after tms", dbgIr, IR_IDCODE);
        chk("dbg off", dbgSel, 1'b0);
        i_bst_probe.walk(8'h00, 1);
    endtask : tResets

    initial begin
        for (int i = 0; i < BSR_LEN; i++) begin
            pat[i] = (i % 3 == 1);
            shin[i] = (i % 5 == 2);
        end
        repeat (8) @(posedge clk);
        pinIn <= pat;
        corePinOut <= ~pat;
        reset <= 1'b0;
        i_bst_probe.testReset();
        tIdcode();
        tBypass();
        tBoundary();
        tDebug();
        tResets();
        finishTest();
    end
endmodule : bst_tap_tb
